// File: scl_pkg.sv
// ****************************************************************
// Register map, field positions, reset values and timing counts.
// ****************************************************************
package scl_pkg;
	// Register indices on the local register port.
	localparam logic [2:0] ADDR_CTL1 = 3'h0;
	localparam logic [2:0] ADDR_CTL2 = 3'h1;
	localparam logic [2:0] ADDR_CTL3 = 3'h2;
	localparam logic [2:0] ADDR_STAT = 3'h3;
	localparam logic [2:0] ADDR_DATA = 3'h4;
	localparam logic [2:0] ADDR_BAUD = 3'h5;
	// Control one fields and writable mask.
	localparam int B_MODON = 6;
	localparam int B_NINE = 4;
	localparam int B_WAKE = 3;
	localparam int B_PEN = 1;
	localparam int B_PODD = 0;
	localparam logic [7:0] CTL1_MASK = 8'h5B;
	// Control two fields.
	localparam int B_TEIE = 7;
	localparam int B_TX_DONE_IRQ_EN = 6;
	localparam int B_RIE = 5;
	localparam int B_QIE = 4;
	localparam int B_TXON = 3;
	localparam int B_RXON = 2;
	localparam int B_STBY = 1;
	localparam int B_BRK = 0;
	// Control three fields; bits 3..0 line up with the error flags.
	localparam int B_DTX = 4;
	localparam logic [7:0] CTL3_MASK = 8'h3F;
	// Status one fields.
	localparam int F_TBE = 7;
	localparam int F_TDN = 6;
	localparam int F_RXF = 5;
	localparam int F_QT = 4;
	localparam int F_OVR = 3;
	localparam int F_NZ = 2;
	localparam int F_FRM = 1;
	localparam int F_PE = 0;
	localparam logic [7:0] RX_FLAGS = 8'h3F;
	// Reset values.
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] STAT_RST = 8'hC0;
	localparam logic [7:0] BAUD_RST = 8'h00;
	// Oversampling and character timing, in sample ticks and bits.
	localparam logic [3:0] OS_LAST = 4'hF;
	localparam logic [3:0] SMP_A = 4'h7;
	localparam logic [3:0] SMP_C = 4'h9;
	localparam logic [3:0] LEN8 = 4'hA;
	localparam logic [3:0] LEN9 = 4'hB;
	localparam logic [3:0] LAST8 = 4'h8;
	localparam logic [3:0] LAST9 = 4'h9;
	// Transmitter and receiver states.
	typedef enum logic {TX_IDLE, TX_SHIFT} scl_tx_st_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} scl_rx_st_t;
endpackage : scl_pkg

// File: scl_line_front.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Receive line synchroniser and oversampling tick divider.
// ****************************************************************
module scl_line_front import scl_pkg::*; (
	// Clock, reset and enable.
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Configuration.
	input wire logic run,
	input wire logic [7:0] baud_div,
	// Line side.
	input wire logic serial_in,
	output logic line_lvl,
	output logic os_tick
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
		logic [7:0] div;
		logic tick;
	} scl_front_t;

	scl_front_t st_r;
	scl_front_t st_nxt;

	// The level moves only once the second and third stages agree.
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = serial_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		if (st_r.s2 == st_r.s3) begin
			st_nxt.lvl = st_r.s3;
		end
		st_nxt.tick = 1'b0;
		if (!run) begin
			st_nxt.div = 8'h00;
		end else if (st_r.div == baud_div) begin
			st_nxt.div = 8'h00;
			st_nxt.tick = 1'b1; // One tick per sixteenth of a bit.
		end else begin
			st_nxt.div = 8'(st_r.div + 8'h01);
		end
	end

	// State register; the line rests high after reset.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.s1 <= 1'b1;
			st_r.s2 <= 1'b1;
			st_r.s3 <= 1'b1;
			st_r.lvl <= 1'b1;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign line_lvl = st_r.lvl;
	assign os_tick = st_r.tick;
endmodule : scl_line_front
`default_nettype wire

// File: scl_control.sv
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// R1 - Enables gate tx done onto transmit irq, rx full and quiet onto receive.
// R2 - Raising tx_on sends an all-ones preamble of one character length.
// R3 - Dropping tx_on finishes the current character before idling high.
// R4 - Toggling tx_on during a character queues one idle character after it.
// R5 - Software leaves tx_on and rx_on alone while module_on is clear.
// R6 - Clearing rx_on stops the receiver and keeps all receiver flags.
// R7 - Standby masks receive irqs; idle line or address mark ends it.
// R8 - Set then clear break_send gives one break then one mark bit.
// R9 - Held break_send sends breaks back to back without mark bits.
// R10 - A break requested before the preamble starts replaces the preamble.
// R11 - rx_ninth_bit takes bit 8, or bit 7 in eight-bit mode, with data.
// R12 - tx_ninth_bit enters the shift register together with the buffer.
// R13 - Software keeps both DMA request enables at zero.
// R14 - Per-flag enables gate overrun, noise, framing, parity onto error irq.
// R15 - Buffer-empty sets on shift load; status read then data write clears.
// R16 - tx_done is set when nothing is buffered or shifting.
// R17 - rx_full sets on buffer load; status read then data read clears.
// R18 - Quiet flag sets after a character length of ones on the line.
// R19 - Quiet flag needs a received character since enable or last clear.
// R20 - Overrun sets on completion with rx_full set; new data dropped.
// R21 - Data read clears overrun only if seen set at the status read.
// R22 - Noise on the line sets the noise flag; cleared by read pair.
// R23 - Clearing module_on forces empty and done, stops transmit irqs.
// R24 - A zero stop bit sets the framing flag; cleared by read pair.
// R25 - Flags hold until their own read-then-access sequence completes; tx_done is instead recomputed from the transmitter state each cycle.
// R26 - Irq outputs are ORs of enabled flags; standby masks receive.
module scl_control import scl_pkg::*; (
	// Clock, reset and enable.
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic ce,
	// Register port.
	input wire logic [2:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	// Serial line.
	input wire logic serial_in,
	output logic serial_out,
	// Interrupt requests.
	output logic tx_irq,
	output logic rx_irq,
	output logic err_irq
);
	// ************************************************************
	// State.
	// ************************************************************
	typedef struct packed {
		logic [7:0] ctl1;
		logic [7:0] ctl2;
		logic [7:0] ctl3;
		logic [7:0] baud;
		logic [7:0] flags;
		logic [7:0] seen;
		scl_tx_st_t tx_st;
		logic tx_brk;
		logic pre_pend;
		logic [10:0] tx_sh;
		logic [3:0] tx_left;
		logic [3:0] tx_os;
		scl_rx_st_t rx_st;
		logic [9:0] rx_sh;
		logic [3:0] rx_bit;
		logic [3:0] rx_os;
		logic [3:0] qos;
		logic [3:0] ones;
		logic [2:0] smp;
		logic rx_nz;
		logic q_arm;
		logic [7:0] rdata;
		logic sout;
		logic tx_irq;
		logic rx_irq;
		logic err_irq;
	} scl_state_t;

	// Data held across reset.
	typedef struct packed {
		logic [7:0] tx_buf;
		logic [7:0] rx_buf;
		logic tx9;
		logic rx9;
	} scl_data_t;

	scl_state_t st_r;
	scl_state_t st_nxt;
	scl_data_t dat_r;
	scl_data_t dat_nxt;
	logic line_lvl;
	logic os_tick;

	// Synchronised receive line and sample tick.
	scl_line_front u_front (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.ce(ce),
		.run(st_r.ctl1[B_MODON]),
		.baud_div(st_r.baud),
		.serial_in(serial_in),
		.line_lvl(line_lvl),
		.os_tick(os_tick)
	);

	// ************************************************************
	// Next state.
	// ************************************************************
	always_comb begin
		logic nine;
		logic [3:0] flen;
		logic [3:0] lastb;
		logic [2:0] sm3;
		logic maj;
		logic pbit;
		logic [10:0] frame;
		logic [7:0] clr;
		logic brk_on;
		nine = st_r.ctl1[B_NINE];
		flen = nine ? LEN9 : LEN8;
		lastb = nine ? LAST9 : LAST8;
		sm3 = {st_r.smp[1:0], line_lvl};
		maj = (sm3[0] & sm3[1]) | (sm3[0] & sm3[2]) | (sm3[1] & sm3[2]);
		pbit = 1'b0;
		frame = 11'h7FF;
		clr = 8'h00;
		brk_on = 1'b0;
		st_nxt = st_r;
		dat_nxt = dat_r;
		st_nxt.rdata = 8'h00;

		// Register reads; status read snapshots the flags.
		if (rd_en) begin
			if (addr == ADDR_CTL1) begin
				st_nxt.rdata = st_r.ctl1;
			end else if (addr == ADDR_CTL2) begin
				st_nxt.rdata = st_r.ctl2;
			end else if (addr == ADDR_CTL3) begin
				st_nxt.rdata = {dat_r.rx9, dat_r.tx9, st_r.ctl3[5:0]};
			end else if (addr == ADDR_STAT) begin
				st_nxt.rdata = st_r.flags;
				st_nxt.seen = st_r.flags; // R25
			end else if (addr == ADDR_DATA) begin
				st_nxt.rdata = dat_r.rx_buf;
				clr = st_r.seen & RX_FLAGS; // R17 R18 R21 R22 R24
			end else if (addr == ADDR_BAUD) begin
				st_nxt.rdata = st_r.baud;
			end
		end

		// Register writes.
		if (wr_en) begin
			if (addr == ADDR_CTL1) begin
				st_nxt.ctl1 = wr_data & CTL1_MASK;
			end else if (addr == ADDR_CTL2) begin
				st_nxt.ctl2 = wr_data;
				if (wr_data[B_TXON] && !st_r.ctl2[B_TXON]) begin
					st_nxt.pre_pend = 1'b1; // R2 R4
				end
				if (wr_data[B_RXON] && !st_r.ctl2[B_RXON]) begin
					st_nxt.q_arm = 1'b0; // R19
				end
			end else if (addr == ADDR_CTL3) begin
				st_nxt.ctl3 = wr_data & CTL3_MASK;
				dat_nxt.tx9 = wr_data[6];
			end else if (addr == ADDR_DATA) begin
				dat_nxt.tx_buf = wr_data;
				clr[F_TBE] = st_r.seen[F_TBE]; // R15
			end else if (addr == ADDR_BAUD) begin
				st_nxt.baud = wr_data;
			end
		end

		// Clears from completed sequences; later sets override.
		st_nxt.flags = st_nxt.flags & ~clr; // R25
		st_nxt.seen = st_nxt.seen & ~clr;
		if (clr[F_QT]) begin
			st_nxt.q_arm = 1'b0; // R19
		end
		brk_on = st_nxt.ctl2[B_BRK] & st_nxt.ctl2[B_TXON];

		// Transmitter: one bit per sixteen ticks.
		if (!st_nxt.ctl1[B_MODON]) begin
			st_nxt.tx_st = TX_IDLE;
			st_nxt.sout = 1'b1;
			st_nxt.pre_pend = 1'b0;
			st_nxt.tx_brk = 1'b0;
			st_nxt.tx_os = 4'h0;
			st_nxt.flags[F_TBE] = 1'b1; // R23
		end else if (os_tick) begin
			st_nxt.tx_os = 4'(st_r.tx_os + 4'h1);
			if (st_r.tx_os == OS_LAST) begin
				if (st_r.tx_st == TX_SHIFT && st_r.tx_left != 4'h0) begin
					st_nxt.sout = st_r.tx_sh[0];
					st_nxt.tx_sh = {1'b1, st_r.tx_sh[10:1]};
					st_nxt.tx_left = 4'(st_r.tx_left - 4'h1);
				end else begin
					// Frame boundary: pick the next frame by priority.
					st_nxt.tx_st = TX_SHIFT;
					st_nxt.tx_left = flen;
					if (st_r.tx_brk && !brk_on) begin
						frame = 11'h7FF; // R8
						st_nxt.tx_left = 4'h1;
						st_nxt.tx_brk = 1'b0;
					end else if (brk_on) begin
						frame = 11'h000; // R9
						st_nxt.tx_brk = 1'b1;
						st_nxt.pre_pend = 1'b0; // R10
					end else if (!st_nxt.ctl2[B_TXON]) begin
						st_nxt.tx_st = TX_IDLE; // R3
						st_nxt.pre_pend = 1'b0;
					end else if (st_nxt.pre_pend) begin
						frame = 11'h7FF; // R2 R4
						st_nxt.pre_pend = 1'b0;
					end else if (!st_nxt.flags[F_TBE]) begin
						pbit = st_r.ctl1[B_PODD];
						if (nine) begin
							pbit = pbit ^ (^dat_nxt.tx_buf);
							frame = {1'b1,
								st_r.ctl1[B_PEN] ? pbit : dat_nxt.tx9,
								dat_nxt.tx_buf, 1'b0}; // R12
						end else begin
							pbit = pbit ^ (^dat_nxt.tx_buf[6:0]);
							frame = {2'b11,
								st_r.ctl1[B_PEN] ? pbit : dat_nxt.tx_buf[7],
								dat_nxt.tx_buf[6:0], 1'b0};
						end
						st_nxt.flags[F_TBE] = 1'b1; // R15
					end else begin
						st_nxt.tx_st = TX_IDLE;
					end
					if (st_nxt.tx_st == TX_SHIFT) begin
						st_nxt.sout = frame[0];
						st_nxt.tx_sh = {1'b1, frame[10:1]};
						st_nxt.tx_left = 4'(st_nxt.tx_left - 4'h1);
					end else begin
						st_nxt.sout = 1'b1;
					end
				end
			end
		end

		// Receiver: frame sampling, quiet line count, flag setting.
		if (!st_r.ctl1[B_MODON] || !st_r.ctl2[B_RXON]) begin
			st_nxt.rx_st = RX_IDLE; // R6
			st_nxt.ones = 4'h0;
			st_nxt.qos = 4'h0;
		end else if (os_tick) begin
			st_nxt.qos = 4'(st_r.qos + 4'h1);
			if (!line_lvl) begin
				st_nxt.ones = 4'h0;
			end else if (st_r.qos == OS_LAST && st_r.ones != flen) begin
				st_nxt.ones = 4'(st_r.ones + 4'h1);
				if (4'(st_r.ones + 4'h1) == flen) begin
					if (st_r.q_arm) begin
						st_nxt.flags[F_QT] = 1'b1; // R18 R19
					end
					if (!st_r.ctl1[B_WAKE]) begin
						st_nxt.ctl2[B_STBY] = 1'b0; // R7
					end
				end
			end
			if (st_r.rx_st == RX_IDLE) begin
				if (!line_lvl) begin
					st_nxt.rx_st = RX_START;
					st_nxt.rx_os = 4'h0;
					st_nxt.rx_bit = 4'h0;
					st_nxt.rx_nz = 1'b0;
				end
			end else begin
				st_nxt.rx_os = 4'(st_r.rx_os + 4'h1);
				if (st_r.rx_os >= SMP_A && st_r.rx_os <= SMP_C) begin
					st_nxt.smp = sm3;
				end
				if (st_r.rx_os == SMP_C) begin
					if (!(&sm3) && (|sm3)) begin
						st_nxt.rx_nz = 1'b1; // R22
					end
					if (st_r.rx_st == RX_START) begin
						st_nxt.rx_st = maj ? RX_IDLE : RX_DATA;
					end else begin
						st_nxt.rx_sh[st_r.rx_bit] = maj;
						st_nxt.rx_bit = 4'(st_r.rx_bit + 4'h1);
					end
				end
			end
		end

		// Character complete: move to buffer or flag overrun.
		if (st_r.rx_st == RX_DATA && st_nxt.rx_st == RX_DATA &&
			st_r.rx_bit == lastb && st_nxt.rx_bit != lastb) begin
			st_nxt.rx_st = RX_IDLE;
			if (st_nxt.flags[F_RXF]) begin
				st_nxt.flags[F_OVR] = 1'b1; // R20
			end else begin
				dat_nxt.rx_buf = st_nxt.rx_sh[7:0];
				dat_nxt.rx9 = nine ? st_nxt.rx_sh[8] : st_nxt.rx_sh[7]; // R11
				st_nxt.flags[F_RXF] = 1'b1; // R17
				st_nxt.q_arm = 1'b1; // R19
				if (!st_nxt.rx_sh[lastb]) begin
					st_nxt.flags[F_FRM] = 1'b1; // R24
				end
				if (st_nxt.rx_nz) begin
					st_nxt.flags[F_NZ] = 1'b1; // R22
				end
				if (st_r.ctl1[B_PEN] && ((nine ? ^st_nxt.rx_sh[8:0] :
					^st_nxt.rx_sh[7:0]) != st_r.ctl1[B_PODD])) begin
					st_nxt.flags[F_PE] = 1'b1;
				end
				if (st_r.ctl1[B_WAKE] &&
					(nine ? st_nxt.rx_sh[8] : st_nxt.rx_sh[7])) begin
					st_nxt.ctl2[B_STBY] = 1'b0; // R7
				end
			end
		end

		// Transmission complete: nothing buffered, queued or shifting.
		st_nxt.flags[F_TDN] = !st_nxt.ctl1[B_MODON] ||
			(st_nxt.flags[F_TBE] && st_nxt.tx_st == TX_IDLE &&
			!st_nxt.pre_pend && !brk_on && !st_nxt.tx_brk); // R16 R23

		// Interrupt outputs, registered.
		st_nxt.tx_irq = st_nxt.ctl1[B_MODON] && // R23
			((st_nxt.flags[F_TBE] && st_nxt.ctl2[B_TEIE] &&
			!st_nxt.ctl3[B_DTX]) || // R13 R15
			(st_nxt.flags[F_TDN] && st_nxt.ctl2[B_TX_DONE_IRQ_EN])); // R1 R26
		st_nxt.rx_irq = !st_nxt.ctl2[B_STBY] && // R7 R26
			((st_nxt.flags[F_RXF] && st_nxt.ctl2[B_RIE]) ||
			(st_nxt.flags[F_QT] && st_nxt.ctl2[B_QIE])); // R1
		st_nxt.err_irq = |(st_nxt.flags[3:0] & st_nxt.ctl3[3:0]); // R14
	end

	// ************************************************************
	// Registers.
	// ************************************************************
	// Control state; reset clears enables and sets the empty flags.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.ctl1 <= CTL_RST;
			st_r.ctl2 <= CTL_RST;
			st_r.ctl3 <= CTL_RST;
			st_r.baud <= BAUD_RST;
			st_r.flags <= STAT_RST;
			st_r.tx_sh <= 11'h7FF;
			st_r.sout <= 1'b1;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	// Data buffers and ninth bits keep their contents across reset.
	always_ff @(posedge ref_clk) begin
		if (ce) begin
			dat_r <= dat_nxt;
		end
	end

	assign rd_data = st_r.rdata;
	assign serial_out = st_r.sout;
	assign tx_irq = st_r.tx_irq;
	assign rx_irq = st_r.rx_irq;
	assign err_irq = st_r.err_irq;
endmodule : scl_control
`default_nettype wire

// File: scl_control_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Port checker for the control and status block.
// ****************************************************************
module scl_control_asserts import scl_pkg::*; (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_n,
	// Register port.
	input wire logic ce,
	input wire logic [2:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] rd_data,
	// Line and interrupts.
	input wire logic serial_out,
	input wire logic tx_irq,
	input wire logic rx_irq,
	input wire logic err_irq
);
	logic mod_r;
	logic [3:0] ie2_r;
	logic [3:0] ie3_r;
	// Shadow copies of the module switch and the interrupt enables.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mod_r <= 1'b0;
			ie2_r <= 4'h0;
			ie3_r <= 4'h0;
		end else if (ce && wr_en) begin
			if (addr == ADDR_CTL1)
				mod_r <= wr_data[B_MODON];
			if (addr == ADDR_CTL2)
				ie2_r <= wr_data[7:4];
			if (addr == ADDR_CTL3)
				ie3_r <= wr_data[3:0];
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	property p_tx_mask;
		ie2_r[3:2] == 2'b00 && $past(ie2_r[3:2]) == 2'b00 |-> !tx_irq;
	endproperty
	a_tx_mask: assert property (p_tx_mask) else $error("tx irq unmasked");
	property p_rx_mask;
		ie2_r[1:0] == 2'b00 && $past(ie2_r[1:0]) == 2'b00 |-> !rx_irq;
	endproperty
	a_rx_mask: assert property (p_rx_mask) else $error("rx irq unmasked");
	property p_done_irq;
		$past(rd_en && addr == ADDR_STAT) && mod_r && ie2_r[2]
			&& rd_data[F_TDN] |-> tx_irq;
	endproperty
	a_done_irq: assert property (p_done_irq) else $error("no done irq");
	property p_err_mask;
		ie3_r == 4'h0 && $past(ie3_r) == 4'h0 |-> !err_irq;
	endproperty
	a_err_mask: assert property (p_err_mask) else $error("err irq unmasked");
	property p_err_or;
		$past(rd_en && addr == ADDR_STAT) && |(rd_data[3:0] & ie3_r)
			|-> err_irq;
	endproperty
	a_err_or: assert property (p_err_or) else $error("err irq missing");
	property p_off_quiet;
		!mod_r && !$past(mod_r) |-> !tx_irq;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("tx irq when off");
	property p_done_empty;
		$past(rd_en && addr == ADDR_STAT) && rd_data[F_TDN] |-> rd_data[F_TBE];
	endproperty
	a_done_empty: assert property (p_done_empty) else $error("done not empty");
	property p_done_idle;
		$past(rd_en && addr == ADDR_STAT) && mod_r && rd_data[F_TDN]
			|-> $past(serial_out);
	endproperty
	a_done_idle: assert property (p_done_idle) else $error("done while low");
endmodule : scl_control_asserts
bind scl_control scl_control_asserts u_chk (.ref_clk(ref_clk),
	.rst_n(rst_n), .ce(ce), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
	.rd_en(rd_en), .rd_data(rd_data), .serial_out(serial_out),
	.tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq));
`default_nettype wire

// File: scl_remote.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Remote serial device: sends frames and decodes what it hears.
// ****************************************************************
module scl_remote (
	// Clock.
	input wire logic ref_clk,
	// Line.
	input wire logic serial_out,
	output logic serial_in
);
	logic [7:0] got;
	int got_cnt;
	// Sends one frame low bit first, sixteen clocks a bit, then idles.
	task automatic send_char(input logic [7:0] d, input logic stop);
		logic [9:0] f;
		f = {stop, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			serial_in <= f[i];
			repeat (16) @(posedge ref_clk);
		end
		serial_in <= 1'b1;
		repeat (32) @(posedge ref_clk);
	endtask : send_char
	// Decodes each frame from its start edge, sampling mid bit.
	initial begin
		serial_in = 1'b1;
		got = 8'h00;
		got_cnt = 0;
		forever begin
			@(negedge serial_out);
			repeat (8) @(posedge ref_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (16) @(posedge ref_clk);
				got[i] = serial_out;
			end
			got_cnt++;
			wait (serial_out === 1'b1);
		end
	end
endmodule : scl_remote
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// Self-checking bench for the control and status block.
// ****************************************************************
module tb_top import scl_pkg::*;;
	logic ref_clk, rst_n, ce, wr_en, rd_en;
	logic serial_in, serial_out, tx_irq, rx_irq, err_irq;
	logic [2:0] addr;
	logic [7:0] wr_data, rd_data, v, b, b2;
	int fail_count, tests_run, seed;
	// Clock at 100 MHz.
	initial ref_clk = 1'b0;
	always #5 ref_clk = ~ref_clk;
	scl_control DUT (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
		.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
		.rd_data(rd_data), .serial_in(serial_in), .serial_out(serial_out),
		.tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq));
	scl_remote u_remote (.ref_clk(ref_clk), .serial_out(serial_out),
		.serial_in(serial_in));
	// Counts a comparison and reports a difference.
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// Expected status with the transmitter idle and the given receive flags.
	function automatic logic [7:0] stat_exp(input logic full,
		input logic quiet);
		logic [7:0] s;
		s = STAT_RST;
		s[F_RXF] = full;
		s[F_QT] = quiet;
		return s;
	endfunction : stat_exp
	// One-cycle register write.
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask : wr
	// One-cycle register read; data taken in the following cycle.
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1 d = rd_data;
	endtask : rd
	// Reads a register and compares the masked value.
	task automatic rchk(input logic [2:0] a, input logic [7:0] m,
		input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(d & m, e);
	endtask : rchk
	// Prints the verdict and ends the run.
	task automatic conclude();
		if (fail_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude
	// Cuts a hang short.
	initial begin
		#600000;
		fail_count++;
		conclude();
	end
	// Main sequence.
	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		addr = 3'h0;
		wr_data = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		fail_count = 0;
		tests_run = 0;
		seed = 32'h335E;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		rchk(ADDR_CTL2, 8'hFF, 8'h00);
		rchk(ADDR_CTL3, 8'h3F, 8'h00);
		rchk(ADDR_STAT, 8'hFF, 8'hC0);
		rchk(3'h6, 8'hFF, 8'h00);
		rchk(3'h7, 8'hFF, 8'h00);
		wr(ADDR_CTL1, 8'h40);
		repeat (3) begin
			v = 8'($random(seed)) & 8'hF0;
			wr(ADDR_CTL2, v);
			rchk(ADDR_CTL2, 8'hFF, v);
			v = 8'($random(seed)) & 8'h4F;
			wr(ADDR_CTL3, v);
			rchk(ADDR_CTL3, 8'h7F, v);
		end
		wr(ADDR_CTL3, 8'h00);
		wr(ADDR_CTL2, 8'h24);
		repeat (250) @(posedge ref_clk);
		rchk(ADDR_STAT, 8'hFF, 8'hC0);
		b = 8'($random(seed));
		u_remote.send_char(b, 1'b1);
		repeat (200) @(posedge ref_clk);
		rchk(ADDR_STAT, 8'hFF, 8'hF0);
		chk(rx_irq, 1'b1);
		rchk(ADDR_CTL3, 8'h80, {b[7], 7'h00});
		rchk(ADDR_DATA, 8'hFF, b);
		rchk(ADDR_STAT, 8'hFF, 8'hC0);
		chk(rx_irq, 1'b0);
		repeat (250) @(posedge ref_clk);
		rchk(ADDR_STAT, 8'hFF, 8'hC0);
		wr(ADDR_CTL2, 8'h26);
		b = 8'($random(seed)) & 8'h7F;
		u_remote.send_char(b, 1'b1);
		rchk(ADDR_STAT, 8'hFF, stat_exp(1'b1, 1'b0));
		chk(rx_irq, 1'b0);
		repeat (200) @(posedge ref_clk);
		chk(rx_irq, 1'b1);
		rchk(ADDR_CTL2, 8'hFF, 8'h24);
		rchk(ADDR_STAT, 8'hFF, stat_exp(1'b1, 1'b1));
		rd(ADDR_DATA, v);
		chk(v, b);
		b = 8'($random(seed));
		b2 = 8'($random(seed)) & 8'h7F;
		u_remote.send_char(b, 1'b1);
		u_remote.send_char(b2, 1'b1);
		rchk(ADDR_STAT, 8'hFF, 8'hE8);
		rchk(ADDR_DATA, 8'hFF, b);
		rchk(ADDR_STAT, 8'hFF, 8'hC0);
		wr(ADDR_CTL3, 8'h02);
		u_remote.send_char(b2, 1'b0);
		rchk(ADDR_STAT, 8'hFF, 8'hE2);
		chk(err_irq, 1'b1);
		rd(ADDR_DATA, v);
		chk(v, b2);
		rchk(ADDR_STAT, 8'hFF, 8'hC0);
		chk(err_irq, 1'b0);
		wr(ADDR_CTL2, 8'h08);
		rchk(ADDR_STAT, 8'h40, 8'h00);
		repeat (200) @(posedge ref_clk);
		b = 8'($random(seed));
		rchk(ADDR_STAT, 8'hC0, 8'hC0);
		wr(ADDR_DATA, b);
		rchk(ADDR_STAT, 8'h40, 8'h00);
		repeat (400) @(posedge ref_clk);
		chk(u_remote.got, b);
		chk(8'(u_remote.got_cnt), 8'h01);
		wr(ADDR_CTL2, 8'h48);
		rchk(ADDR_STAT, 8'hC0, 8'hC0);
		chk(tx_irq, 1'b1);
		wr(ADDR_CTL2, 8'h49);
		repeat (60) @(posedge ref_clk);
		wr(ADDR_CTL2, 8'h48);
		repeat (300) @(posedge ref_clk);
		chk(u_remote.got, 8'h00);
		chk(8'(u_remote.got_cnt), 8'h02);
		wr(ADDR_DATA, b);
		wr(ADDR_CTL1, 8'h00);
		rchk(ADDR_STAT, 8'hC0, 8'hC0);
		chk(tx_irq, 1'b0);
		conclude();
	end
endmodule : tb_top
`default_nettype wire
